/* src/imurc_batch_counter.sv */
/*
 * counter of batching events with threshold flag.
 * assumes event and clear strobes are one-cycle pulses on ref_clk_i.
 */
`timescale 1ns/1ps
module imurc_batch_counter
(
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        event_i,
    input  wire logic [10:0] threshold_i,
    input  wire logic        count_clear_i,
    input  wire logic        flag_clear_i,
    output logic             flag_o
);
    typedef struct packed {
        logic [10:0] count;
        logic        flag;
    } imurc_bcnt_s;

    imurc_bcnt_s st_reg;
    imurc_bcnt_s st_next;

    // threshold zero never fires: a zero match would only fire when the 11-bit count wraps
    always_comb
    begin
        st_next = st_reg;
        if (flag_clear_i)
            st_next.flag = 1'b0;
        if (count_clear_i)
            st_next.count = 11'h000;
        else if (event_i)
        begin
            if (threshold_i != 11'h000 && st_reg.count + 11'h001 == threshold_i)
            begin
                st_next.count = 11'h000;
                st_next.flag  = 1'b1;                                     // set wins
            end
            else
                st_next.count = st_reg.count + 11'h001;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flag_o = st_reg.flag;
endmodule

/* src/imurc_config_top.sv */
/*
 * second-pin routing, identification and accel/gyro rate and range
 * registers, with decoded settings as registered outputs.
 * assumes an 8-bit strobed register port; events and controls come
 * from logic on ref_clk_i, so no synchronisers.
 */
// Behaviour
// - second pin is OR of routed sources and embedded-function routing.
// - routing drives the pin only while no I3C dynamic address exists.
// - route bit 7 is zero; bits 6..0 select seven event sources.
// - enabled batch-counter flag reaches the second pin.
// - enabled queue threshold, full and overrun reach the second pin.
// - enabled accel and gyro data-ready reach the second pin.
// - temperature ready raises in-band interrupt under I3C with merge set.
// - identification register is read-only and returns a constant.
// - accel rate codes 0..1010 decode to off and 12.5 Hz..6.66 kHz.
// - accel code 1011 is 1.6 Hz low power, else 12.5 Hz.
// - accel range 2, 16 or 2, 4, 8 g per range mode.
// - accel filter select picks first or second stage output.
// - gyro rate resets off; same sequence; 1011 not available.
// - gyro range 250, 500, 1000, 2000 dps.
// - gyro low range override forces 125 dps.
// - batch counter resets and sets its flag at threshold.
// - merge control moves every interrupt onto the first pin.
`timescale 1ns/1ps
`include "imurc_defines.svh"
module imurc_config_top
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      nrst_i,
    // register port
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    output logic                           reg_rvalid_o,
    // event sources
    input  wire logic                      ev_batch_i,
    input  wire logic [10:0]               batch_threshold_i,
    input  wire logic                      batch_count_clear_i,
    input  wire logic                      batch_flag_clear_i,
    input  wire logic                      ev_queue_full_i,
    input  wire logic                      ev_queue_overrun_i,
    input  wire logic                      ev_queue_threshold_i,
    input  wire logic                      ev_temp_ready_i,
    input  wire logic                      ev_gyro_ready_i,
    input  wire logic                      ev_accel_ready_i,
    input  wire logic                      embedded_func_route_second_i,
    // controls held in neighbouring registers
    input  wire logic                      i3c_addr_assigned_i,
    input  wire logic                      merge_irqs_first_pin_i,
    input  wire logic                      accel_hiperf_disable_i,
    input  wire logic                      accel_range_mode_i,
    input  wire logic                      gyro_hiperf_disable_i,
    // interrupt outputs
    output logic                           second_irq_pin_o,
    output logic                           first_irq_merge_o,
    output logic                           ibi_request_o,
    output logic                           batch_count_reached_flag_o,
    // decoded configuration
    output imurc_pkg::imurc_rate_e         accel_rate_o,
    output imurc_pkg::imurc_perf_e         accel_perf_o,
    output logic                           accel_rate_illegal_o,
    output imurc_pkg::imurc_accel_range_e  accel_range_o,
    output logic                           accel_second_filter_sel_o,
    output imurc_pkg::imurc_rate_e         gyro_rate_o,
    output imurc_pkg::imurc_perf_e         gyro_perf_o,
    output logic                           gyro_rate_illegal_o,
    output imurc_pkg::imurc_gyro_range_e   gyro_range_o
);
    import imurc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0]  route;
        logic [7:0]  accel_ctrl;
        logic [7:0]  gyro_ctrl;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        pin2;
        logic        pin1_merge;
        logic        ibi;
        imurc_rate_e accel_rate;
        imurc_perf_e accel_perf;
        logic        accel_filt2;
        imurc_rate_e gyro_rate;
        imurc_perf_e gyro_perf;
        logic        accel_bad;
        logic        gyro_bad;
    } imurc_top_s;

    imurc_top_s   st_reg;
    imurc_top_s   st_next;
    logic         batch_flag;
    logic [6:0]   routed;
    logic         any_routed;

    imurc_range_if rng ();

    // ****************************************
    // submodules
    // ****************************************
    // batch events counted against the threshold
    imurc_batch_counter u_batch
    (
        .ref_clk_i     (ref_clk_i),
        .nrst_i        (nrst_i),
        .event_i       (ev_batch_i),
        .threshold_i   (batch_threshold_i),
        .count_clear_i (batch_count_clear_i),
        .flag_clear_i  (batch_flag_clear_i),
        .flag_o        (batch_flag)
    );

    // range fields feed the decoder from the register
    assign rng.accel_range_code        = st_reg.accel_ctrl[`IMURC_RANGE_MSB:`IMURC_RANGE_LSB];
    assign rng.accel_range_mode        = accel_range_mode_i;
    assign rng.gyro_range_code         = st_reg.gyro_ctrl[`IMURC_RANGE_MSB:`IMURC_RANGE_LSB];
    assign rng.gyro_low_range_override = st_reg.gyro_ctrl[`IMURC_GYRO_LOW_OVR];

    imurc_range_decode u_range
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .rng       (rng)
    );

    // ****************************************
    // event routing
    // ****************************************
    // each enabled source, in register bit order
    always_comb
    begin
        routed                       = 7'h00;
        routed[`IMURC_RT_BATCH_FLAG] = st_reg.route[`IMURC_RT_BATCH_FLAG]
                                       & batch_flag;
        routed[`IMURC_RT_Q_FULL]     = st_reg.route[`IMURC_RT_Q_FULL]
                                       & ev_queue_full_i;
        routed[`IMURC_RT_Q_OVERRUN]  = st_reg.route[`IMURC_RT_Q_OVERRUN]
                                       & ev_queue_overrun_i;
        routed[`IMURC_RT_Q_THRESH]   = st_reg.route[`IMURC_RT_Q_THRESH]
                                       & ev_queue_threshold_i;
        routed[`IMURC_RT_TEMP_RDY]   = st_reg.route[`IMURC_RT_TEMP_RDY]
                                       & ev_temp_ready_i;
        routed[`IMURC_RT_GYRO_RDY]   = st_reg.route[`IMURC_RT_GYRO_RDY]
                                       & ev_gyro_ready_i;
        routed[`IMURC_RT_ACCEL_RDY]  = st_reg.route[`IMURC_RT_ACCEL_RDY]
                                       & ev_accel_ready_i;
    end

    // embedded-function sources join ungated
    assign any_routed = (|routed) | embedded_func_route_second_i;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next        = st_reg;
        st_next.rvalid = 1'b0;

        // register writes; fixed-zero bits are masked off
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `IMURC_OFS_ROUTE:
                    st_next.route = reg_wdata_i & `IMURC_MASK_ROUTE;
                `IMURC_OFS_ACCEL:
                    st_next.accel_ctrl = reg_wdata_i & `IMURC_MASK_ACCEL;
                `IMURC_OFS_GYRO:
                    st_next.gyro_ctrl = reg_wdata_i & `IMURC_MASK_GYRO;
                default:
                    st_next.route = st_reg.route;
            endcase
        end

        // register reads, one cycle latency; unmapped reads return zero
        if (reg_rd_i)
        begin
            st_next.rvalid = 1'b1;
            case (reg_addr_i)
                `IMURC_OFS_ROUTE: st_next.rdata = st_reg.route;
                `IMURC_OFS_IDENT: st_next.rdata = `IMURC_IDENT_VALUE;
                `IMURC_OFS_ACCEL: st_next.rdata = st_reg.accel_ctrl;
                `IMURC_OFS_GYRO:  st_next.rdata = st_reg.gyro_ctrl;
                default:          st_next.rdata = 8'h00;
            endcase
        end

        // physical pin only without an i3c address; merge moves all to pin 1
        st_next.pin2       = 1'b0;
        st_next.pin1_merge = 1'b0;
        if (!i3c_addr_assigned_i)
        begin
            if (merge_irqs_first_pin_i)
                st_next.pin1_merge = any_routed;
            else
                st_next.pin2 = any_routed;
        end

        // in-band interrupt from temperature ready, only merged under i3c
        st_next.ibi = i3c_addr_assigned_i & merge_irqs_first_pin_i
                      & routed[`IMURC_RT_TEMP_RDY];

        // rate and mode decode, registered so outputs leave from flops
        st_next.accel_rate = imurc_rate_decode(
            st_reg.accel_ctrl[`IMURC_RATE_MSB:`IMURC_RATE_LSB],
            accel_hiperf_disable_i, 1'b1);
        st_next.accel_perf = imurc_perf_decode(st_next.accel_rate,
                                               accel_hiperf_disable_i);
        st_next.accel_filt2 = st_reg.accel_ctrl[`IMURC_ACCEL_FILT2];
        st_next.gyro_rate = imurc_rate_decode(
            st_reg.gyro_ctrl[`IMURC_RATE_MSB:`IMURC_RATE_LSB],
            gyro_hiperf_disable_i, 1'b0);
        st_next.gyro_perf = imurc_perf_decode(st_next.gyro_rate,
                                              gyro_hiperf_disable_i);
        st_next.accel_bad = (st_next.accel_rate == IMURC_RATE_BAD);
        st_next.gyro_bad  = (st_next.gyro_rate == IMURC_RATE_BAD);
    end

    // ****************************************
    // registers
    // ****************************************
    // gyro rate field resets to power-down
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            st_reg             <= '0;
            st_reg.route       <= `IMURC_RST_ROUTE;
            st_reg.accel_ctrl  <= `IMURC_RST_ACCEL;
            st_reg.gyro_ctrl   <= `IMURC_RST_GYRO;
        end
        else
            st_reg <= st_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_o                = st_reg.rdata;
    assign reg_rvalid_o               = st_reg.rvalid;
    assign second_irq_pin_o           = st_reg.pin2;
    assign first_irq_merge_o          = st_reg.pin1_merge;
    assign ibi_request_o              = st_reg.ibi;
    assign batch_count_reached_flag_o = batch_flag;
    assign accel_rate_o               = st_reg.accel_rate;
    assign accel_perf_o               = st_reg.accel_perf;
    assign accel_rate_illegal_o       = st_reg.accel_bad;
    assign accel_range_o              = rng.accel_range;
    assign accel_second_filter_sel_o  = st_reg.accel_filt2;
    assign gyro_rate_o                = st_reg.gyro_rate;
    assign gyro_perf_o                = st_reg.gyro_perf;
    assign gyro_rate_illegal_o        = st_reg.gyro_bad;
    assign gyro_range_o               = rng.gyro_range;
endmodule

/* src/imurc_defines.svh */
/*
 * offsets, field positions, reset values and masks of the
 * routing and rate/range configuration slice.
 * assumes an 8-bit register port with 8-bit addresses.
 */
`ifndef IMURC_DEFINES_SVH
`define IMURC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define IMURC_OFS_ROUTE      8'h0e
`define IMURC_OFS_IDENT      8'h0f
`define IMURC_OFS_ACCEL      8'h10
`define IMURC_OFS_GYRO       8'h11

// ****************************************
// reset values and writable masks
// ****************************************
`define IMURC_RST_ROUTE      8'h00
`define IMURC_RST_ACCEL      8'h00
`define IMURC_RST_GYRO       8'h00
`define IMURC_MASK_ROUTE     8'h7f
`define IMURC_MASK_ACCEL     8'hfe
`define IMURC_MASK_GYRO      8'hfe
// identification value, arbitrary
`define IMURC_IDENT_VALUE    8'h5a

// ****************************************
// field positions
// ****************************************
`define IMURC_RT_ACCEL_RDY   0
`define IMURC_RT_GYRO_RDY    1
`define IMURC_RT_TEMP_RDY    2
`define IMURC_RT_Q_THRESH    3
`define IMURC_RT_Q_OVERRUN   4
`define IMURC_RT_Q_FULL      5
`define IMURC_RT_BATCH_FLAG  6
`define IMURC_RATE_MSB       7
`define IMURC_RATE_LSB       4
`define IMURC_RANGE_MSB      3
`define IMURC_RANGE_LSB      2
`define IMURC_ACCEL_FILT2    1
`define IMURC_GYRO_LOW_OVR   1

`endif

/* src/imurc_pkg.sv */
/*
 * types and shared decode functions of the configuration slice.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package imurc_pkg;

    // selected output data rate
    typedef enum logic [3:0] {
        IMURC_RATE_OFF   = 4'h0, IMURC_RATE_12P5 = 4'h1, IMURC_RATE_26   = 4'h2,
        IMURC_RATE_52    = 4'h3, IMURC_RATE_104  = 4'h4, IMURC_RATE_208  = 4'h5,
        IMURC_RATE_416   = 4'h6, IMURC_RATE_833  = 4'h7, IMURC_RATE_1K66 = 4'h8,
        IMURC_RATE_3K33  = 4'h9, IMURC_RATE_6K66 = 4'ha, IMURC_RATE_1P6  = 4'hb,
        IMURC_RATE_BAD   = 4'hf
    } imurc_rate_e;

    // operating mode that goes with the rate
    typedef enum logic [1:0] {
        IMURC_PERF_OFF = 2'h0, IMURC_PERF_LOW = 2'h1,
        IMURC_PERF_NORMAL = 2'h2, IMURC_PERF_HIGH = 2'h3
    } imurc_perf_e;

    typedef enum logic [1:0] {
        IMURC_XL_2G = 2'h0, IMURC_XL_4G = 2'h1, IMURC_XL_8G = 2'h2, IMURC_XL_16G = 2'h3
    } imurc_accel_range_e;

    typedef enum logic [2:0] {
        IMURC_G_125 = 3'h0, IMURC_G_250 = 3'h1, IMURC_G_500 = 3'h2,
        IMURC_G_1000 = 3'h3, IMURC_G_2000 = 3'h4
    } imurc_gyro_range_e;

    // rate code to rate; 1011 only exists for the accel, 1.6 Hz in low power, else 12.5 Hz
    function automatic imurc_rate_e imurc_rate_decode(input logic [3:0] code,
                                                      input logic       hpd,
                                                      input logic       is_accel);
        imurc_rate_e r;
        r = IMURC_RATE_BAD;
        if (code <= 4'ha)
            r = imurc_rate_e'(code);
        else if (code == 4'hb && is_accel)
            r = hpd ? IMURC_RATE_1P6 : IMURC_RATE_12P5;
        return r;
    endfunction

    // mode follows the rate when high performance is disabled
    function automatic imurc_perf_e imurc_perf_decode(input imurc_rate_e rate,
                                                      input logic        hpd);
        imurc_perf_e p;
        p = IMURC_PERF_HIGH;
        if (rate == IMURC_RATE_OFF || rate == IMURC_RATE_BAD)
            p = IMURC_PERF_OFF;
        else if (hpd && (rate <= IMURC_RATE_52 || rate == IMURC_RATE_1P6))
            p = IMURC_PERF_LOW;
        else if (hpd && rate <= IMURC_RATE_208)
            p = IMURC_PERF_NORMAL;
        return p;
    endfunction

endpackage

/* src/imurc_range_decode.sv */
/*
 * registered full-scale decode for accel and gyro.
 * assumes field values come from registers on the same clock.
 */
`timescale 1ns/1ps
module imurc_range_decode
(
    input  wire logic   ref_clk_i,
    input  wire logic   nrst_i,
    imurc_range_if.dec  rng
);
    import imurc_pkg::*;

    typedef struct packed {
        imurc_accel_range_e accel;
        imurc_gyro_range_e  gyro;
    } imurc_rdec_s;

    imurc_rdec_s st_reg;
    imurc_rdec_s st_next;

    // decode both fields
    always_comb
    begin
        st_next = st_reg;
        case (rng.accel_range_code)
            2'b00:   st_next.accel = IMURC_XL_2G;
            2'b01:   st_next.accel = rng.accel_range_mode ? IMURC_XL_2G
                                                          : IMURC_XL_16G;
            2'b10:   st_next.accel = IMURC_XL_4G;
            default: st_next.accel = IMURC_XL_8G;
        endcase
        case (rng.gyro_range_code)
            2'b00:   st_next.gyro = IMURC_G_250;
            2'b01:   st_next.gyro = IMURC_G_500;
            2'b10:   st_next.gyro = IMURC_G_1000;
            default: st_next.gyro = IMURC_G_2000;
        endcase
        if (rng.gyro_low_range_override)
            st_next.gyro = IMURC_G_125;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            st_reg <= '{accel: IMURC_XL_2G, gyro: IMURC_G_250};
        else
            st_reg <= st_next;
    end

    assign rng.accel_range = st_reg.accel;
    assign rng.gyro_range  = st_reg.gyro;
endmodule

/* src/imurc_range_if.sv */
/*
 * carrier between the top and the full-scale decoder.
 * assumes both ends share ref_clk_i.
 */
`timescale 1ns/1ps
interface imurc_range_if;
    import imurc_pkg::*;
    logic [1:0]         accel_range_code;
    logic               accel_range_mode;
    logic [1:0]         gyro_range_code;
    logic               gyro_low_range_override;
    imurc_accel_range_e accel_range;
    imurc_gyro_range_e  gyro_range;

    modport top (output accel_range_code, accel_range_mode, gyro_range_code,
                 output gyro_low_range_override, input accel_range, gyro_range);
    modport dec (input accel_range_code, accel_range_mode, gyro_range_code,
                 input gyro_low_range_override, output accel_range, gyro_range);
endinterface

/* testbench/imurc_config_props.sv */
/* concurrent checks on the ports of the configuration slice.
   assumes one clock and an active-low synchronous reset. */
`timescale 1ns/1ps
`include "imurc_defines.svh"
module imurc_config_props
(
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       reg_rvalid_o,
    input  wire logic       ev_batch_i,
    input  wire logic       embedded_func_route_second_i,
    input  wire logic       i3c_addr_assigned_i,
    input  wire logic       merge_irqs_first_pin_i,
    input  wire logic       second_irq_pin_o,
    input  wire logic       first_irq_merge_o,
    input  wire logic       ibi_request_o,
    input  wire logic       batch_count_reached_flag_o
);
    // ****************************************
    // register port and interrupt checks
    // ****************************************
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_ident_read: assert property (reg_rd_i && reg_addr_i == `IMURC_OFS_IDENT
        |=> reg_rvalid_o && reg_rdata_o == `IMURC_IDENT_VALUE) else $error("ident read wrong");
    chk_route_msb: assert property (reg_rd_i && reg_addr_i == `IMURC_OFS_ROUTE
        |=> !reg_rdata_o[7]) else $error("route bit 7 not zero");
    chk_cfg_lsb: assert property (reg_rd_i && reg_addr_i inside {8'h10, 8'h11}
        |=> !reg_rdata_o[0]) else $error("config bit 0 not zero");
    chk_pin_quiet: assert property (i3c_addr_assigned_i
        |=> !second_irq_pin_o && !first_irq_merge_o) else $error("pin active under i3c");
    chk_merge_moves: assert property (merge_irqs_first_pin_i
        |=> !second_irq_pin_o) else $error("pin2 while merged");
    chk_split_keeps: assert property (!merge_irqs_first_pin_i
        |=> !first_irq_merge_o) else $error("merge output while split");
    chk_embedded_or: assert property (embedded_func_route_second_i
        && !i3c_addr_assigned_i && !merge_irqs_first_pin_i |=> second_irq_pin_o)
        else $error("embedded not on pin");
    chk_ibi_cause: assert property (ibi_request_o
        |-> $past(i3c_addr_assigned_i) && $past(merge_irqs_first_pin_i))
        else $error("ibi without i3c and merge");
    chk_flag_cause: assert property ($rose(batch_count_reached_flag_o)
        |-> $past(ev_batch_i)) else $error("flag set without event");

    cover property (ibi_request_o);
    cover property (batch_count_reached_flag_o && second_irq_pin_o);
    cover property (reg_rvalid_o);
endmodule
bind imurc_config_top imurc_config_props imurc_config_props_inst (.*);

/* testbench/imurc_host_model.sv */
/* host side of the register port: one strobe per byte.
   assumes a request is taken at the edge that sees its strobe. */
`timescale 1ns/1ps
module imurc_host_model
(
    input  wire logic       ref_clk_i,
    output logic      [7:0] addr_o = 8'h00,
    output logic      [7:0] wdata_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i
);
    // write: held to the taking edge, then scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // read: data counts only with its valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = (rvalid_i === 1'b1) ? rdata_i : ~rdata_i;
    endtask
endmodule

/* testbench/tb_top.sv */
/* self-checking bench of the configuration slice.
   assumes the host model and checker compile first. */
`timescale 1ns/1ps
module tb_top;
    import imurc_pkg::*;
    logic               ref_clk_i = 1'b0, nrst_i = 1'b0, ev_batch_i = 1'b0;
    logic               batch_flag_clear_i = 1'b0, embedded_func_route_second_i = 1'b0;
    logic               i3c_addr_assigned_i = 1'b0, merge_irqs_first_pin_i = 1'b0;
    logic               accel_hiperf_disable_i = 1'b1, gyro_hiperf_disable_i = 1'b1;
    logic               accel_range_mode_i = 1'b0;
    logic [10:0]        batch_threshold_i = 11'h002;
    logic [7:0]         reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
    logic               reg_wr_i, reg_rd_i, reg_rvalid_o, second_irq_pin_o, first_irq_merge_o;
    logic               ibi_request_o, batch_count_reached_flag_o, accel_second_filter_sel_o;
    logic               accel_rate_illegal_o, gyro_rate_illegal_o;
    logic [5:0]         ev = 6'h00;
    logic [3:0]         c, r;
    logic [1:0]         pe;
    imurc_rate_e        accel_rate_o, gyro_rate_o;
    imurc_perf_e        accel_perf_o, gyro_perf_o;
    imurc_accel_range_e accel_range_o;
    imurc_gyro_range_e  gyro_range_o;
    int                 err_count = 0, n_compared = 0, cyc = 0;

    imurc_host_model imurc_host_model_inst (.ref_clk_i, .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o),
        .rvalid_i(reg_rvalid_o));
    imurc_config_top imurc_config_top_inst (.*, .batch_count_clear_i(1'b0),
        .ev_accel_ready_i(ev[0]), .ev_gyro_ready_i(ev[1]), .ev_temp_ready_i(ev[2]),
        .ev_queue_threshold_i(ev[3]), .ev_queue_overrun_i(ev[4]), .ev_queue_full_i(ev[5]));

    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        imurc_host_model_inst.rd(a, rd_v);
        chk("rdata", rd_v, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        imurc_host_model_inst.wr(a, d);
    endtask

    initial
        forever #20 ref_clk_i = ~ref_clk_i;
    // ceiling far above the ~150-cycle run
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rdc(8'h11, 8'h00);
        wr(8'h0e, 8'hff);
        rdc(8'h0e, 8'h7f);
        wr(8'h0f, 8'h00);
        rdc(8'h0f, 8'h5a);
        rdc(8'h20, 8'h00);
        // each of the six ev sources alone, then all but it
        for (int b = 0; b < 6; b++)
        begin
            wr(8'h0e, 8'(1 << b));
            ev <= 6'(1 << b);
            step();
            chk("pin on", 8'(second_irq_pin_o), 8'h01);
            @(posedge ref_clk_i);
            ev <= ~6'(1 << b);
            step();
            chk("pin off", 8'(second_irq_pin_o), 8'h00);
        end
        // threshold 2: flag on second event, then cleared
        wr(8'h0e, 8'h40);
        ev <= 6'h00;
        for (int k = 0; k < 3; k++)
        begin
            ev_batch_i <= 1'b1;
            @(posedge ref_clk_i);
            ev_batch_i <= 1'b0;
            #1;
            chk("flag", 8'(batch_count_reached_flag_o), 8'(k == 1));
            @(posedge ref_clk_i);
            batch_flag_clear_i <= (k == 1);
            #1;
            chk("batch pin", 8'(second_irq_pin_o), 8'(k == 1));
            @(posedge ref_clk_i);
            batch_flag_clear_i <= 1'b0;
        end
        wr(8'h0e, 8'h04);
        ev <= 6'h04;
        merge_irqs_first_pin_i <= 1'b1;
        step();
        chk("merged", 8'(first_irq_merge_o), 8'h01);
        @(posedge ref_clk_i);
        i3c_addr_assigned_i <= 1'b1;
        step();
        chk("ibi", 8'(ibi_request_o), 8'h01);
        @(posedge ref_clk_i);
        merge_irqs_first_pin_i <= 1'b0;
        step();
        chk("ibi split", 8'(ibi_request_o), 8'h00);
        @(posedge ref_clk_i);
        i3c_addr_assigned_i <= 1'b0;
        ev <= 6'h00;
        embedded_func_route_second_i <= 1'b1;
        wr(8'h0e, 8'h00);
        step();
        chk("embedded", 8'(second_irq_pin_o), 8'h01);
        // every rate code; range and filter fields ride along
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            wr(8'h10, {c, c[1:0], c[2], 1'b0});
            wr(8'h11, {c, c[1:0], c[2], 1'b0});
            step();
            r = (c > 4'hb) ? 4'hf : c;
            pe = (r == 4'h0 || r == 4'hf) ? 2'h0 : (r < 4'h4 || r == 4'hb) ? 2'h1 : 2'h2;
            pe = (r > 4'h5 && r < 4'hb) ? 2'h3 : pe;
            chk("arate", 8'(accel_rate_o), 8'(r));
            chk("aperf", 8'(accel_perf_o), 8'(pe));
            chk("aillegal", 8'(accel_rate_illegal_o), 8'(c > 4'hb));
            chk("grate", 8'(gyro_rate_o), (c > 4'ha) ? 8'h0f : 8'(c));
            chk("gperf", 8'(gyro_perf_o), (c == 4'hb) ? 8'h00 : 8'(pe));
            chk("gillegal", 8'(gyro_rate_illegal_o), 8'(c > 4'ha));
            chk("arange", 8'(accel_range_o), 8'(c[0] ? (c[1] ? 2 : 3) : c[1]));
            chk("grange", 8'(gyro_range_o), c[2] ? 8'h00 : 8'(c[1:0]) + 8'h01);
            chk("filter", 8'(accel_second_filter_sel_o), 8'(c[2]));
        end
        @(posedge ref_clk_i);
        {accel_hiperf_disable_i, gyro_hiperf_disable_i} <= 2'h0;
        accel_range_mode_i <= 1'b1;
        wr(8'h10, 8'hb4);
        wr(8'h11, 8'h10);
        step();
        chk("gperf hp", 8'(gyro_perf_o), 8'(IMURC_PERF_HIGH));
        chk("arate hp", 8'(accel_rate_o), 8'(IMURC_RATE_12P5));
        chk("aperf hp", 8'(accel_perf_o), 8'(IMURC_PERF_HIGH));
        chk("arange mode", 8'(accel_range_o), 8'(IMURC_XL_2G));
        give_verdict();
    end
endmodule
